/* hw/smpd_pkg.sv */
/*
 * smpd_pkg: register map, field positions, reset values and types of the
 * signal monitor peak detector.
 * assumes: apb slave with 32-bit data, one register per aligned word.
 */
package smpd_pkg;
   // printed offsets are not multiples of four: they are register indexes
   localparam logic [11:0] IDX_SYNC_CTL   = 12'h26f;
   localparam logic [11:0] IDX_MON_CTL    = 12'h270;
   localparam logic [11:0] IDX_PERIOD0    = 12'h271;
   localparam logic [11:0] IDX_PERIOD1    = 12'h272;
   localparam logic [11:0] IDX_PERIOD2    = 12'h273;
   localparam logic [11:0] IDX_STAT_CTL   = 12'h274;
   localparam logic [11:0] IDX_RESULT0    = 12'h275;
   localparam logic [11:0] IDX_RESULT1    = 12'h276;
   localparam logic [11:0] IDX_RESULT2    = 12'h277;
   localparam logic [11:0] IDX_FRAME_CNT  = 12'h278;

   localparam int ADDR_W   = 14;
   localparam int SAMPLE_W = 14;
   localparam int RESULT_W = 20;
   localparam int PERIOD_W = 24;

   localparam int SYNC_EN_BIT   = 0;
   localparam int SYNC_NEXT_BIT = 1;
   localparam int PEAK_EN_BIT   = 1;
   localparam int UPDATE_BIT    = 4;

   localparam logic [7:0]  RST_SYNC_CTL = 8'h00;
   localparam logic [7:0]  RST_MON_CTL  = 8'h00;
   localparam logic [23:0] RST_PERIOD   = 24'h000080;
   localparam logic [2:0]  RST_SEL      = 3'h1;
   localparam logic [2:0]  SEL_PEAK     = 3'h1;
   localparam logic [23:0] PERIOD_ONE   = 24'h000001;

   typedef struct packed {
      logic                 psel;
      logic                 penable;
      logic                 pwrite;
      logic [ADDR_W-1:0]    paddr;
      logic [31:0]          pwdata;
   } smpd_apb_req_t;

   typedef enum logic [1:0] {
      SMPD_IDLE   = 2'b00,
      SMPD_ACCESS = 2'b01
   } smpd_apb_st_t;
endpackage

/* hw/smpd_sync2.sv */
/*
 * smpd_sync2: two-stage synchroniser for one pin-level signal.
 * assumes: input is asynchronous to clk_sys.
 */
`timescale 1ns/1ns
module smpd_sync2 (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic stage1_ff;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stage1_ff <= 1'b0;
         syncOut   <= 1'b0;
      end else begin
         stage1_ff <= asyncIn;
         syncOut   <= stage1_ff;
      end
   end
endmodule

/* hw/smpd_top.sv */
/*
 * smpd_top: peak detecting signal monitor for one converter channel,
 * with byte-wide registers behind an apb slave.
 * assumes: samples are signed, arrive on clk_sys with a valid strobe;
 * the sysref pin is asynchronous and is synchronised here.
 */
`timescale 1ns/1ns
module smpd_top (
   input  wire logic                          clk_sys,
   input  wire logic                          rst_b,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [smpd_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [31:0]                   pwdata,
   input  wire logic [3:0]                    pstrb,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          sampleValid,
   input  wire logic [smpd_pkg::SAMPLE_W-1:0] sampleData,
   input  wire logic                          sysrefPin,
   output logic      [smpd_pkg::RESULT_W-1:0] statusResult
);
   smpd_pkg::smpd_apb_req_t apbReq;
   smpd_pkg::smpd_apb_st_t  apbSt_ff;
   logic [7:0]  syncCtl_ff;
   logic [7:0]  monCtl_ff;
   logic [23:0] period_ff;
   logic [2:0]  resultSel_ff;
   logic        update_ff;
   logic [19:0] status_ff;
   logic [7:0]  frameCnt_ff;
   logic [7:0]  statusFrame_ff;
   logic [23:0] periodCnt_ff;
   logic [19:0] peak_ff;
   logic [19:0] result_ff;
   logic        sysrefSync;
   logic        sysrefPrev_ff;
   logic        sysrefEdge;
   logic        realign;
   logic        expire;
   logic        wrTake;
   logic        rdTake;
   logic [11:0] regIdx;
   logic        addrOk;
   logic [19:0] magnitude;
   logic [31:0] nxt_prdata;

   assign apbReq = '{psel, penable, pwrite, paddr, pwdata};
   assign regIdx = apbReq.paddr[smpd_pkg::ADDR_W-1:2];
   assign addrOk = apbReq.paddr[1:0] == 2'h0 &&
                   regIdx >= smpd_pkg::IDX_SYNC_CTL &&
                   regIdx <= smpd_pkg::IDX_FRAME_CNT;
   assign wrTake = apbSt_ff == smpd_pkg::SMPD_ACCESS && apbReq.pwrite &&
                   addrOk && pstrb[0];
   assign rdTake = apbSt_ff == smpd_pkg::SMPD_ACCESS && !apbReq.pwrite;

   smpd_sync2 uSysref (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .asyncIn (sysrefPin),
      .syncOut (sysrefSync)
   );

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sysrefPrev_ff <= 1'b0;
      end else begin
         sysrefPrev_ff <= sysrefSync;
      end
   end

   assign sysrefEdge = sysrefSync && !sysrefPrev_ff;
   // continuous mode realigns on every edge, next mode only while still armed
   assign realign = sysrefEdge &&
                    syncCtl_ff[smpd_pkg::SYNC_EN_BIT];
   assign expire  = periodCnt_ff <= smpd_pkg::PERIOD_ONE;

   // apb: no wait states, pready high in the access phase only
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         apbSt_ff <= smpd_pkg::SMPD_IDLE;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         if (apbSt_ff == smpd_pkg::SMPD_IDLE) begin
            if (apbReq.psel && !apbReq.penable) begin
               apbSt_ff <= smpd_pkg::SMPD_ACCESS;
               pready   <= 1'b1;
               pslverr  <= !addrOk;
            end
         end else begin
            apbSt_ff <= smpd_pkg::SMPD_IDLE;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
         end
      end
   end

   always_comb begin
      nxt_prdata = 32'h0;
      if (regIdx == smpd_pkg::IDX_SYNC_CTL) begin
         nxt_prdata[1:0] = syncCtl_ff[1:0];
      end else if (regIdx == smpd_pkg::IDX_MON_CTL) begin
         nxt_prdata[smpd_pkg::PEAK_EN_BIT] = monCtl_ff[smpd_pkg::PEAK_EN_BIT];
      end else if (regIdx == smpd_pkg::IDX_PERIOD0) begin
         nxt_prdata[7:0] = period_ff[7:0];
      end else if (regIdx == smpd_pkg::IDX_PERIOD1) begin
         nxt_prdata[7:0] = period_ff[15:8];
      end else if (regIdx == smpd_pkg::IDX_PERIOD2) begin
         nxt_prdata[7:0] = period_ff[23:16];
      end else if (regIdx == smpd_pkg::IDX_STAT_CTL) begin
         nxt_prdata[2:0] = resultSel_ff;
         nxt_prdata[smpd_pkg::UPDATE_BIT] = update_ff;
      end else if (regIdx == smpd_pkg::IDX_RESULT0) begin
         nxt_prdata[7:0] = status_ff[7:0];
      end else if (regIdx == smpd_pkg::IDX_RESULT1) begin
         nxt_prdata[7:0] = status_ff[15:8];
      end else if (regIdx == smpd_pkg::IDX_RESULT2) begin
         nxt_prdata[3:0] = status_ff[19:16];
      end else if (regIdx == smpd_pkg::IDX_FRAME_CNT) begin
         nxt_prdata[7:0] = statusFrame_ff;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0;
      end else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite &&
                   apbSt_ff == smpd_pkg::SMPD_IDLE) begin
         prdata <= addrOk ? nxt_prdata : 32'h0;
      end
   end

   // sync control: hardware clear of the enable loses to a register write and to reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         syncCtl_ff <= smpd_pkg::RST_SYNC_CTL;
      end else begin
         if (wrTake && regIdx == smpd_pkg::IDX_SYNC_CTL) begin
            syncCtl_ff <= {6'h0, apbReq.pwdata[1:0]};
         end else if (realign && syncCtl_ff[smpd_pkg::SYNC_NEXT_BIT]) begin
            syncCtl_ff[smpd_pkg::SYNC_EN_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         monCtl_ff    <= smpd_pkg::RST_MON_CTL;
         period_ff    <= smpd_pkg::RST_PERIOD;
         resultSel_ff <= smpd_pkg::RST_SEL;
      end else if (wrTake) begin
         if (regIdx == smpd_pkg::IDX_MON_CTL) begin
            monCtl_ff <= apbReq.pwdata[7:0] & 8'h02;
         end else if (regIdx == smpd_pkg::IDX_PERIOD0) begin
            period_ff[7:0] <= apbReq.pwdata[7:0];
         end else if (regIdx == smpd_pkg::IDX_PERIOD1) begin
            period_ff[15:8] <= apbReq.pwdata[7:0];
         end else if (regIdx == smpd_pkg::IDX_PERIOD2) begin
            period_ff[23:16] <= apbReq.pwdata[7:0];
         end else if (regIdx == smpd_pkg::IDX_STAT_CTL) begin
            resultSel_ff <= apbReq.pwdata[2:0];
         end
      end
   end

   // update bit reads 1 for the cycle after the write, then self clears
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         update_ff      <= 1'b0;
         status_ff      <= 20'h0;
         statusFrame_ff <= 8'h0;
      end else begin
         update_ff <= wrTake && regIdx == smpd_pkg::IDX_STAT_CTL &&
                      apbReq.pwdata[smpd_pkg::UPDATE_BIT];
         if (update_ff) begin
            status_ff      <= (resultSel_ff == smpd_pkg::SEL_PEAK) ?
                              result_ff : 20'h0;
            statusFrame_ff <= frameCnt_ff;
         end
      end
   end

   // widen before negating so the most negative code keeps its magnitude
   assign magnitude = sampleData[smpd_pkg::SAMPLE_W-1] ?
                      -(20'($signed(sampleData))) : 20'(sampleData);

   // period counter: realign restarts the window like an expiry but does not count a frame
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         periodCnt_ff <= smpd_pkg::RST_PERIOD;
         frameCnt_ff  <= 8'h0;
      end else begin
         if (realign) begin
            periodCnt_ff <= period_ff;
         end else if (expire) begin
            periodCnt_ff <= period_ff;
            frameCnt_ff  <= frameCnt_ff + 8'h1;
         end else begin
            periodCnt_ff <= periodCnt_ff - smpd_pkg::PERIOD_ONE;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         peak_ff   <= 20'h0;
         result_ff <= 20'h0;
      end else begin
         if (!monCtl_ff[smpd_pkg::PEAK_EN_BIT]) begin
            peak_ff <= 20'h0;
         end else if (expire && !realign) begin
            result_ff <= peak_ff;
            peak_ff   <= sampleValid ? magnitude : 20'h0;
         end else if (realign) begin
            peak_ff <= 20'h0;
         end else if (sampleValid && magnitude > peak_ff) begin
            peak_ff <= magnitude;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         statusResult <= 20'h0;
      end else begin
         statusResult <= status_ff;
      end
   end

   property p_no_sync_when_off;
      @(posedge clk_sys) disable iff (!rst_b)
      (sysrefEdge && !syncCtl_ff[0] && !expire) |=>
         periodCnt_ff == $past(periodCnt_ff) - 24'h1;
   endproperty
   a_no_sync_when_off: assert property (p_no_sync_when_off)
      else $error("sysref realigned while sync disabled");

   property p_next_clears;
      @(posedge clk_sys) disable iff (!rst_b)
      (realign && syncCtl_ff[1] && !wrTake) |=> !syncCtl_ff[0];
   endproperty
   a_next_clears: assert property (p_next_clears)
      else $error("next sync did not clear enable");

   property p_realign_load;
      @(posedge clk_sys) disable iff (!rst_b)
      realign |=> periodCnt_ff == $past(period_ff);
   endproperty
   a_realign_load: assert property (p_realign_load)
      else $error("realign did not restart period");

   property p_peak_off;
      @(posedge clk_sys) disable iff (!rst_b)
      !monCtl_ff[1] |=> peak_ff == 20'h0;
   endproperty
   a_peak_off: assert property (p_peak_off)
      else $error("peak tracked while disabled");

   property p_period_reset;
      @(posedge clk_sys) $rose(rst_b) |-> period_ff == 24'h80;
   endproperty
   a_period_reset: assert property (p_period_reset)
      else $error("period reset value wrong");

   sequence s_update_write;
      wrTake && regIdx == smpd_pkg::IDX_STAT_CTL && apbReq.pwdata[4];
   endsequence
   property p_update;
      @(posedge clk_sys) disable iff (!rst_b)
      s_update_write ##1 (resultSel_ff == 3'h1) |=>
         status_ff == $past(result_ff) ##1 !update_ff;
   endproperty
   a_update: assert property (p_update)
      else $error("result update did not copy or clear");

   property p_top_nibble;
      @(posedge clk_sys) disable iff (!rst_b)
      (rdTake && regIdx == smpd_pkg::IDX_RESULT2) |-> prdata[31:4] == 28'h0;
   endproperty
   a_top_nibble: assert property (p_top_nibble)
      else $error("status upper bits not zero");

   property p_frame;
      @(posedge clk_sys) disable iff (!rst_b)
      (expire && !realign) |=> frameCnt_ff == $past(frameCnt_ff) + 8'h1;
   endproperty
   a_frame: assert property (p_frame)
      else $error("frame counter did not advance");

   property p_latch;
      @(posedge clk_sys) disable iff (!rst_b)
      (expire && !realign && monCtl_ff[1]) |=> result_ff == $past(peak_ff);
   endproperty
   a_latch: assert property (p_latch)
      else $error("peak not latched at expiry");

   property p_sel_other;
      @(posedge clk_sys) disable iff (!rst_b)
      (update_ff && resultSel_ff != smpd_pkg::SEL_PEAK) |=>
         status_ff == 20'h0;
   endproperty
   a_sel_other: assert property (p_sel_other)
      else $error("status not zero for other selection");

   property p_continuous_keeps;
      @(posedge clk_sys) disable iff (!rst_b)
      (realign && !syncCtl_ff[1] && !wrTake) |=> syncCtl_ff[0];
   endproperty
   a_continuous_keeps: assert property (p_continuous_keeps)
      else $error("continuous sync lost its enable");

   property p_hold_peak;
      @(posedge clk_sys) disable iff (!rst_b)
      (monCtl_ff[1] && !expire && !realign && sampleValid &&
       magnitude > peak_ff) |=> peak_ff == $past(magnitude);
   endproperty
   a_hold_peak: assert property (p_hold_peak)
      else $error("peak did not take larger magnitude");

   property p_expire_reload;
      @(posedge clk_sys) disable iff (!rst_b)
      (expire && !realign) |=> periodCnt_ff == $past(period_ff);
   endproperty
   a_expire_reload: assert property (p_expire_reload)
      else $error("period counter not reloaded at expiry");

   property p_frame_hold;
      @(posedge clk_sys) disable iff (!rst_b)
      !(expire && !realign) |=> $stable(frameCnt_ff);
   endproperty
   a_frame_hold: assert property (p_frame_hold)
      else $error("frame counter moved without expiry");
endmodule

/* testbench/smpd_tb.sv */
/*
 * testbench: register, peak, frame count and sysref alignment checks of
 * smpd_top through its apb slave.
 * assumes: the slave answers every transfer with pready; period 16 after
 * setup.
 */
`timescale 1ns/1ns
module testbench;
   logic                          clk_sys;
   logic                          rst_b;
   logic                          psel;
   logic                          penable;
   logic                          pwrite;
   logic [smpd_pkg::ADDR_W-1:0]   paddr;
   logic [31:0]                   pwdata;
   logic [3:0]                    pstrb;
   logic [31:0]                   prdata;
   logic                          pready;
   logic                          pslverr;
   logic                          sampleValid;
   logic [smpd_pkg::SAMPLE_W-1:0] sampleData;
   logic [smpd_pkg::SAMPLE_W-1:0] peakSample;
   logic                          sysrefPin;
   logic [smpd_pkg::RESULT_W-1:0] statusResult;
   logic                          sysrefRun;
   logic                          alt;
   logic [2:0]                    sysCnt;
   logic [31:0]                   rdData;
   logic                          rdErr;
   logic [7:0]                    diff;
   logic [11:0]                   rstIdx [8];
   logic [7:0]                    rstVal [8];
   logic [13:0]                   smp [4];
   logic [19:0]                   mag [4];
   int                            miscompares;
   int                            testsRun;

   smpd_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sampleValid(sampleValid), .sampleData(sampleData),
      .sysrefPin(sysrefPin), .statusResult(statusResult));

   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h0;
      sampleValid = 1'b1;
      sampleData = '0;
      peakSample = '0;
      sysrefPin = 1'b0;
      sysrefRun = 1'b0;
      alt = 1'b0;
      sysCnt = 3'h0;
      miscompares = 0;
      testsRun = 0;
   end

   always #5 clk_sys = ~clk_sys;

   // peak alternates with a small value so the held maximum is exercised
   always @(posedge clk_sys) begin
      alt <= ~alt;
      sampleData <= alt ? peakSample : 14'h0005;
      sysCnt <= sysCnt + 3'h1;
      sysrefPin <= sysrefRun & sysCnt[2];
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] idx,
         input logic [31:0] data, input logic [3:0] strb,
         input logic [1:0] off);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, off};
      pwdata <= data;
      pstrb <= strb;
      @(posedge clk_sys);
      penable <= 1'b1;
      // only the watchdog ends a wait for pready
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] idx, input logic [31:0] data);
      apb(1'b1, idx, data, 4'h1, 2'b00);
   endtask

   task automatic chkRd(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0, 4'h1, 2'b00);
      check(rdData, exp);
      check({31'h0, rdErr}, 32'h0);
   endtask

   // both snapshots sit 160 cycles apart, ten periods of 16
   task automatic frameDiff(output logic [7:0] d);
      logic [7:0] a;
      wr(smpd_pkg::IDX_STAT_CTL, 32'h11);
      apb(1'b0, smpd_pkg::IDX_FRAME_CNT, 32'h0, 4'h1, 2'b00);
      a = rdData[7:0];
      repeat (154) @(posedge clk_sys);
      wr(smpd_pkg::IDX_STAT_CTL, 32'h11);
      apb(1'b0, smpd_pkg::IDX_FRAME_CNT, 32'h0, 4'h1, 2'b00);
      d = rdData[7:0] - a;
   endtask

   task automatic peakCheck(input logic [13:0] s, input logic [19:0] e);
      peakSample <= s;
      repeat (40) @(posedge clk_sys);
      wr(smpd_pkg::IDX_STAT_CTL, 32'h11);
      chkRd(smpd_pkg::IDX_RESULT0, {24'h0, e[7:0]});
      chkRd(smpd_pkg::IDX_RESULT1, {24'h0, e[15:8]});
      chkRd(smpd_pkg::IDX_RESULT2, {28'h0, e[19:16]});
      check({12'h0, statusResult}, {12'h0, e});
   endtask

   task automatic finish_test;
      if (miscompares == 0 && testsRun > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      finish_test();
   end

   initial begin
      rstIdx = '{12'h26f, 12'h270, 12'h271, 12'h272, 12'h273, 12'h274,
                 12'h275, 12'h277};
      rstVal = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
      smp = '{14'h3448, 14'h0123, 14'h2000, 14'h1fff};
      mag = '{20'h00bb8, 20'h00123, 20'h02000, 20'h01fff};
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         chkRd(rstIdx[i], {24'h0, rstVal[i]});
      end
      apb(1'b0, 12'h000, 32'h0, 4'h1, 2'b00);
      check({rdErr, rdData[30:0]}, 32'h80000000);
      apb(1'b0, smpd_pkg::IDX_MON_CTL, 32'h0, 4'h1, 2'b01);
      check({31'h0, rdErr}, 32'h1);
      // a write with its low strobe clear must leave the byte alone
      apb(1'b1, smpd_pkg::IDX_PERIOD1, 32'hff, 4'h0, 2'b00);
      chkRd(smpd_pkg::IDX_PERIOD1, 32'h0);
      wr(smpd_pkg::IDX_PERIOD2, 32'ha5);
      chkRd(smpd_pkg::IDX_PERIOD2, 32'ha5);
      wr(smpd_pkg::IDX_PERIOD2, 32'h00);
      wr(smpd_pkg::IDX_PERIOD0, 32'h10);
      chkRd(smpd_pkg::IDX_PERIOD0, 32'h10);
      repeat (200) @(posedge clk_sys);
      peakCheck(14'h3448, 20'h0);
      wr(smpd_pkg::IDX_MON_CTL, 32'hff);
      chkRd(smpd_pkg::IDX_MON_CTL, 32'h02);
      for (int i = 0; i < 4; i++) begin
         peakCheck(smp[i], mag[i]);
      end
      chkRd(smpd_pkg::IDX_STAT_CTL, 32'h01);
      wr(smpd_pkg::IDX_STAT_CTL, 32'h12);
      chkRd(smpd_pkg::IDX_RESULT0, 32'h0);
      wr(smpd_pkg::IDX_STAT_CTL, 32'h01);
      frameDiff(diff);
      check({24'h0, diff}, 32'ha);
      sysrefRun <= 1'b1;
      frameDiff(diff);
      check({24'h0, diff}, 32'ha);
      wr(smpd_pkg::IDX_SYNC_CTL, 32'h01);
      frameDiff(diff);
      check({24'h0, diff}, 32'h0);
      chkRd(smpd_pkg::IDX_SYNC_CTL, 32'h01);
      wr(smpd_pkg::IDX_SYNC_CTL, 32'h03);
      repeat (20) @(posedge clk_sys);
      chkRd(smpd_pkg::IDX_SYNC_CTL, 32'h02);
      frameDiff(diff);
      check({24'h0, diff}, 32'ha);
      sysrefRun <= 1'b0;
      finish_test();
   end
endmodule
